//--- hdl/idpage_pkg.sv
// Shared constants and types for the identify parameter page generator.
// Assumes one 200 MHz clock, a synchronous active-low reset and AXI4-Lite access.
package idpage_pkg;

	// ****************************************
	// Page layout
	// ****************************************
	localparam logic [7:0] LAST_IDX = 8'hFF;
	localparam logic [7:0] W_GENCFG = 8'h00;
	localparam logic [7:0] W_DEF_CYL = 8'h01;
	localparam logic [7:0] W_DEF_HEADS = 8'h03;
	localparam logic [7:0] W_DEF_SPT = 8'h06;
	localparam logic [7:0] W_TOTAL_MSW = 8'h07;
	localparam logic [7:0] W_TOTAL_LSW = 8'h08;
	localparam logic [7:0] W_SER_USER = 8'h0A;
	localparam logic [7:0] W_SER_UID = 8'h0F;
	localparam logic [7:0] W_SER_END = 8'h14;
	localparam logic [7:0] W_BUF_TYPE = 8'h14;
	localparam logic [7:0] W_BUF_SIZE = 8'h15;
	localparam logic [7:0] W_ECC = 8'h16;
	localparam logic [7:0] W_MAX_MULTI = 8'h2F;
	localparam logic [7:0] W_CAPS = 8'h31;
	localparam logic [7:0] W_PIO_MODE = 8'h33;
	localparam logic [7:0] W_VALID = 8'h35;
	localparam logic [7:0] W_CUR_CYL = 8'h36;
	localparam logic [7:0] W_CUR_HEADS = 8'h37;
	localparam logic [7:0] W_CUR_SPT = 8'h38;
	localparam logic [7:0] W_CAP_LSW = 8'h39;
	localparam logic [7:0] W_CAP_MSW = 8'h3A;
	localparam logic [7:0] W_MULTI = 8'h3B;
	localparam logic [7:0] W_LBA_LSW = 8'h3C;
	localparam logic [7:0] W_LBA_MSW = 8'h3D;
	localparam logic [7:0] W_DMA = 8'h3F;
	localparam logic [7:0] W_ADV_PIO = 8'h40;
	localparam logic [7:0] W_DMA_MIN = 8'h41;
	localparam logic [7:0] W_DMA_REC = 8'h42;
	localparam logic [7:0] W_ERASE = 8'h5A;
	localparam logic [7:0] W_APM = 8'h5B;
	localparam logic [7:0] W_SECURITY = 8'h80;
	localparam logic [7:0] W_POWER = 8'hA0;

	// ****************************************
	// Fixed word values
	// ****************************************
	localparam logic [15:0] V_GENCFG = 16'h044A;
	localparam logic [15:0] V_BUF_TYPE = 16'h0002;
	localparam logic [15:0] V_BUF_SIZE = 16'h0002;
	localparam logic [15:0] V_ECC = 16'h0004;
	localparam logic [15:0] V_MAX_MULTI = 16'h0001;
	localparam logic [15:0] V_CAPS = 16'h0B00;
	localparam logic [15:0] V_PIO_MODE = 16'h0200;
	localparam logic [15:0] V_VALID = 16'h0003;
	localparam logic [7:0] V_MULTI_FLAG = 8'h01;
	localparam logic [2:0] V_DMA_SUPP = 3'h7;
	localparam logic [15:0] V_ADV_PIO = 16'h0003;
	localparam logic [15:0] V_DMA_NS = 16'h0078;
	localparam logic [1:0] DMA_NONE = 2'h0;

	// ****************************************
	// Register map and reset values
	// ****************************************
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_DEF_GEOM = 8'h04;
	localparam logic [7:0] OFF_DEF_SPT = 8'h08;
	localparam logic [7:0] OFF_TOTAL = 8'h0C;
	localparam logic [7:0] OFF_CUR_GEOM = 8'h10;
	localparam logic [7:0] OFF_CUR_SPT = 8'h14;
	localparam logic [7:0] OFF_MODE = 8'h18;
	localparam logic [7:0] OFF_LIVE_A = 8'h1C;
	localparam logic [7:0] OFF_LIVE_B = 8'h20;
	localparam logic [7:0] OFF_SER0 = 8'h24;
	localparam logic [7:0] OFF_SER1 = 8'h28;
	localparam logic [7:0] OFF_SER2 = 8'h2C;
	localparam int unsigned CTRL_START = 0;
	localparam int unsigned CTRL_DONE = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [15:0] RST_CYL = 16'h0100;
	localparam logic [15:0] RST_HEADS = 16'h0010;
	localparam logic [15:0] RST_SPT = 16'h0020;
	localparam logic [31:0] RST_TOTAL = 32'h0002_0000;
	localparam logic [79:0] RST_SER = 80'h2020_2020_2020_2020_2020;

	// Geometry, capacity, modes and live values that shape the page.
	typedef struct packed {
		logic [15:0] def_cyl;
		logic [15:0] def_heads;
		logic [15:0] def_spt;
		logic [31:0] total;
		logic [15:0] cur_cyl;
		logic [15:0] cur_heads;
		logic [15:0] cur_spt;
		logic [7:0] multi;
		logic [1:0] dma_sel;
		logic [15:0] erase_time;
		logic [15:0] apm;
		logic [15:0] sec_status;
		logic [15:0] pwr_mode;
		logic [79:0] user_ser;
	} cfg_t;

	localparam cfg_t CFG_RST = '{def_cyl: RST_CYL, def_heads: RST_HEADS, def_spt: RST_SPT,
		total: RST_TOTAL, cur_cyl: RST_CYL, cur_heads: RST_HEADS, cur_spt: RST_SPT,
		multi: 8'h00, dma_sel: DMA_NONE, erase_time: 16'h0000, apm: 16'h0000,
		sec_status: 16'h0000, pwr_mode: 16'h0000, user_ser: RST_SER};

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_PREP = 3'b010,
		ST_SEND = 3'b100
	} fsm_t;

endpackage : idpage_pkg

//--- hdl/idpage_top.sv
// Identify parameter page generator with an AXI4-Lite register slave.
// Assumes the read-sector transfer engine drains page words by valid/ready.
`timescale 1ns/1ps
module idpage_top #(
	// Factory identifier; the value is arbitrary.
	parameter logic [79:0] UNIQUE_ID = 80'h3030_3030_3030_3030_3031
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Command decoder request
	input wire logic ident_start,
	// Page word stream toward the sector transfer engine
	output logic [15:0] page_data,
	output logic page_valid,
	output logic page_last,
	input wire logic page_ready,
	// Status
	output logic busy
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		idpage_pkg::fsm_t state;
		logic [7:0] idx;
		logic [15:0] page_data;
		logic page_valid;
		logic page_last;
		logic done;
		logic busy;
		idpage_pkg::cfg_t cfg;
		idpage_pkg::cfg_t snap;
		logic [31:0] product;
		logic awready;
		logic aw_hold;
		logic [7:0] aw_addr;
		logic wready;
		logic w_hold;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} regs_t;

	regs_t r;
	regs_t next_r;
	logic [7:0] fetch_idx;
	logic [15:0] fetch_word;

	// ****************************************
	// Helpers
	// ****************************************

	// Merges the written byte lanes into the old register value.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[b * 8 +: 8] = wd[b * 8 +: 8];
			end
		end
		return res;
	endfunction : merge

	// True for every mapped register offset.
	function automatic logic hit(input logic [7:0] a);
		return a <= idpage_pkg::OFF_SER2 && a[1:0] == 2'b00;
	endfunction : hit

	// Current register contents as software reads them.
	function automatic logic [31:0] reg_val(input regs_t s, input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (a)
			idpage_pkg::OFF_CTRL: v = {30'h0, s.done, s.state != idpage_pkg::ST_IDLE};
			idpage_pkg::OFF_DEF_GEOM: v = {s.cfg.def_heads, s.cfg.def_cyl};
			idpage_pkg::OFF_DEF_SPT: v = {16'h0000, s.cfg.def_spt};
			idpage_pkg::OFF_TOTAL: v = s.cfg.total;
			idpage_pkg::OFF_CUR_GEOM: v = {s.cfg.cur_heads, s.cfg.cur_cyl};
			idpage_pkg::OFF_CUR_SPT: v = {16'h0000, s.cfg.cur_spt};
			idpage_pkg::OFF_MODE: v = {22'h0, s.cfg.dma_sel, s.cfg.multi};
			idpage_pkg::OFF_LIVE_A: v = {s.cfg.apm, s.cfg.erase_time};
			idpage_pkg::OFF_LIVE_B: v = {s.cfg.pwr_mode, s.cfg.sec_status};
			idpage_pkg::OFF_SER0: v = s.cfg.user_ser[79:48];
			idpage_pkg::OFF_SER1: v = s.cfg.user_ser[47:16];
			idpage_pkg::OFF_SER2: v = {16'h0000, s.cfg.user_ser[15:0]};
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction : reg_val

	// ****************************************
	// Word lookup
	// ****************************************

	// Index of the word that will be loaded into the output register next.
	assign fetch_idx = (r.state == idpage_pkg::ST_SEND) ? r.idx + 8'h01 : 8'h00;

	page_word #(
		.UNIQUE_ID(UNIQUE_ID)
	) u_word (
		.idx(fetch_idx),
		.cfg(r.snap),
		.product(r.product),
		.word(fetch_word)
	);

	// ****************************************
	// Next state
	// ****************************************

	// Bus slave, register file and page sequencer.
	always_comb begin
		logic [31:0] wv;
		logic [47:0] prod;
		logic start;
		wv = merge(reg_val(r, r.aw_addr), r.w_data, r.w_strb);
		prod = 48'(r.snap.cur_cyl) * 48'(r.snap.cur_heads) * 48'(r.snap.cur_spt);
		start = ident_start;
		next_r = r;

		// Address and data are taken independently, in either order.
		if (awvalid && r.awready) begin
			next_r.aw_hold = 1'b1;
			next_r.aw_addr = awaddr;
		end
		if (wvalid && r.wready) begin
			next_r.w_hold = 1'b1;
			next_r.w_data = wdata;
			next_r.w_strb = wstrb;
		end
		if (r.bvalid && bready) begin
			next_r.bvalid = 1'b0;
		end

		// Register write once both halves are held.
		if (r.aw_hold && r.w_hold && !r.bvalid) begin
			next_r.aw_hold = 1'b0;
			next_r.w_hold = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp = hit(r.aw_addr) ? idpage_pkg::RESP_OKAY : idpage_pkg::RESP_SLVERR;
			unique case (r.aw_addr)
				idpage_pkg::OFF_CTRL: begin
					if (r.w_strb[0] && r.w_data[idpage_pkg::CTRL_START]) begin
						start = 1'b1;
					end
					if (r.w_strb[0] && r.w_data[idpage_pkg::CTRL_DONE]) begin
						next_r.done = 1'b0;
					end
				end
				idpage_pkg::OFF_DEF_GEOM: {next_r.cfg.def_heads, next_r.cfg.def_cyl} = wv;
				idpage_pkg::OFF_DEF_SPT: next_r.cfg.def_spt = wv[15:0];
				idpage_pkg::OFF_TOTAL: next_r.cfg.total = wv;
				idpage_pkg::OFF_CUR_GEOM: {next_r.cfg.cur_heads, next_r.cfg.cur_cyl} = wv;
				idpage_pkg::OFF_CUR_SPT: next_r.cfg.cur_spt = wv[15:0];
				idpage_pkg::OFF_MODE: begin
					next_r.cfg.multi = wv[7:0];
					next_r.cfg.dma_sel = wv[9:8];
				end
				idpage_pkg::OFF_LIVE_A: {next_r.cfg.apm, next_r.cfg.erase_time} = wv;
				idpage_pkg::OFF_LIVE_B: {next_r.cfg.pwr_mode, next_r.cfg.sec_status} = wv;
				idpage_pkg::OFF_SER0: next_r.cfg.user_ser[79:48] = wv;
				idpage_pkg::OFF_SER1: next_r.cfg.user_ser[47:16] = wv;
				idpage_pkg::OFF_SER2: next_r.cfg.user_ser[15:0] = wv[15:0];
				default: next_r.bresp = idpage_pkg::RESP_SLVERR;
			endcase
		end
		next_r.awready = !next_r.aw_hold && !next_r.bvalid;
		next_r.wready = !next_r.w_hold && !next_r.bvalid;

		// Register read, one outstanding at a time.
		if (r.rvalid && rready) begin
			next_r.rvalid = 1'b0;
		end
		if (arvalid && r.arready) begin
			next_r.rvalid = 1'b1;
			next_r.rdata = reg_val(r, araddr);
			next_r.rresp = hit(araddr) ? idpage_pkg::RESP_OKAY : idpage_pkg::RESP_SLVERR;
		end
		next_r.arready = !next_r.rvalid;

		// Page sequencer; a start while busy is ignored.
		unique case (r.state)
			idpage_pkg::ST_IDLE: begin
				if (start) begin
					next_r.snap = r.cfg;
					next_r.state = idpage_pkg::ST_PREP;
				end
			end
			idpage_pkg::ST_PREP: begin
				next_r.product = prod[31:0];
				next_r.idx = 8'h00;
				next_r.page_data = fetch_word;
				next_r.page_valid = 1'b1;
				next_r.page_last = 1'b0;
				next_r.state = idpage_pkg::ST_SEND;
			end
			idpage_pkg::ST_SEND: begin
				if (page_ready) begin
					if (r.page_last) begin
						next_r.page_valid = 1'b0;
						next_r.page_last = 1'b0;
						next_r.done = 1'b1;
						next_r.state = idpage_pkg::ST_IDLE;
					end else begin
						next_r.idx = fetch_idx;
						next_r.page_data = fetch_word;
						next_r.page_last = fetch_idx == idpage_pkg::LAST_IDX;
					end
				end
			end
		endcase
		// Busy is registered so that the status pin comes straight from a flip-flop.
		next_r.busy = next_r.state != idpage_pkg::ST_IDLE;
	end

	// ****************************************
	// Registers
	// ****************************************

	// Synchronous reset; configuration returns to its defaults.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '0;
			r.state <= idpage_pkg::ST_IDLE;
			r.cfg <= idpage_pkg::CFG_RST;
			r.snap <= idpage_pkg::CFG_RST;
		end else begin
			r <= next_r;
		end
	end

	// Outputs come straight from the state register.
	assign awready = r.awready;
	assign wready = r.wready;
	assign bresp = r.bresp;
	assign bvalid = r.bvalid;
	assign arready = r.arready;
	assign rdata = r.rdata;
	assign rresp = r.rresp;
	assign rvalid = r.rvalid;
	assign page_data = r.page_data;
	assign page_valid = r.page_valid;
	assign page_last = r.page_last;
	assign busy = r.busy;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// A stalled word holds its value.
	property p_hold;
		page_valid && !page_ready |=> page_valid && $stable(page_data) && $stable(r.idx);
	endproperty
	a_hold: assert property (p_hold) else $error("page word changed while stalled");

	// Words advance one index at a time.
	property p_step;
		page_valid && page_ready && !page_last |=> r.idx == $past(r.idx) + 8'h01;
	endproperty
	a_step: assert property (p_step) else $error("page index skipped");

	// The last word is word 255 and the stream ends after it.
	property p_last;
		page_valid && page_last && page_ready |-> r.idx == 8'hFF ##1 !page_valid;
	endproperty
	a_last: assert property (p_last) else $error("page length wrong");

	// Word 0 follows the preparation cycle.
	property p_first;
		r.state == idpage_pkg::ST_PREP |=> page_valid && r.idx == 8'h00
			&& page_data == 16'h044A;
	endproperty
	a_first: assert property (p_first) else $error("word 0 wrong");

	// Multiple setting word mirrors the frozen count.
	property p_multi;
		page_valid && r.idx == 8'h3B |-> page_data == {8'h01, r.snap.multi};
	endproperty
	a_multi: assert property (p_multi) else $error("word 59 wrong");

	// DMA word selects at most one mode and claims all three.
	property p_dma;
		page_valid && r.idx == 8'h3F |-> $onehot0(page_data[10:8]) && page_data[2:0] == 3'h7
			&& page_data[15:11] == 5'h00 && page_data[7:3] == 5'h00;
	endproperty
	a_dma: assert property (p_dma) else $error("word 63 wrong");

	// Capacity word is the low half of the geometry product.
	property p_cap;
		page_valid && r.idx == 8'h39 |-> page_data
			== 16'(32'(r.snap.cur_cyl) * 32'(r.snap.cur_heads) * 32'(r.snap.cur_spt));
	endproperty
	a_cap: assert property (p_cap) else $error("word 57 wrong");

	// Trailing reserved words read zero.
	property p_zero;
		page_valid && r.idx > 8'hA0 |-> page_data == 16'h0000;
	endproperty
	a_zero: assert property (p_zero) else $error("reserved word not zero");

	// Frozen fields do not move while the page is sent.
	property p_frozen;
		busy && $past(busy) |-> $stable(r.snap);
	endproperty
	a_frozen: assert property (p_frozen) else $error("snapshot changed mid page");

endmodule : idpage_top

//--- hdl/page_word.sv
// Combinational lookup of one parameter page word by index.
// Assumes the caller holds cfg and product stable while the page is sent.
`timescale 1ns/1ps
module page_word #(
	parameter logic [79:0] UNIQUE_ID = 80'h3030_3030_3030_3030_3031
) (
	// Word selection
	input wire logic [7:0] idx,
	input wire idpage_pkg::cfg_t cfg,
	input wire logic [31:0] product,
	// Word value
	output logic [15:0] word
);

	// Serial string slots count from the left-hand character.
	logic [2:0] slot;
	assign slot = (idx < idpage_pkg::W_SER_UID) ? 3'(idx - idpage_pkg::W_SER_USER)
		: 3'(idx - idpage_pkg::W_SER_UID);

	// Every index not named below reads as zero.
	always_comb begin
		word = 16'h0000;
		if (idx >= idpage_pkg::W_SER_USER && idx < idpage_pkg::W_SER_UID) begin
			word = cfg.user_ser[(3'h4 - slot) * 16 +: 16];
		end else if (idx >= idpage_pkg::W_SER_UID && idx < idpage_pkg::W_SER_END) begin
			word = UNIQUE_ID[(3'h4 - slot) * 16 +: 16];
		end else begin
			unique case (idx)
				idpage_pkg::W_GENCFG: word = idpage_pkg::V_GENCFG;
				idpage_pkg::W_DEF_CYL: word = cfg.def_cyl;
				idpage_pkg::W_DEF_HEADS: word = cfg.def_heads;
				idpage_pkg::W_DEF_SPT: word = cfg.def_spt;
				idpage_pkg::W_TOTAL_MSW: word = cfg.total[31:16];
				idpage_pkg::W_TOTAL_LSW: word = cfg.total[15:0];
				idpage_pkg::W_BUF_TYPE: word = idpage_pkg::V_BUF_TYPE;
				idpage_pkg::W_BUF_SIZE: word = idpage_pkg::V_BUF_SIZE;
				idpage_pkg::W_ECC: word = idpage_pkg::V_ECC;
				idpage_pkg::W_MAX_MULTI: word = idpage_pkg::V_MAX_MULTI;
				idpage_pkg::W_CAPS: word = idpage_pkg::V_CAPS;
				idpage_pkg::W_PIO_MODE: word = idpage_pkg::V_PIO_MODE;
				idpage_pkg::W_VALID: word = idpage_pkg::V_VALID;
				idpage_pkg::W_CUR_CYL: word = cfg.cur_cyl;
				idpage_pkg::W_CUR_HEADS: word = cfg.cur_heads;
				idpage_pkg::W_CUR_SPT: word = cfg.cur_spt;
				idpage_pkg::W_CAP_LSW: word = product[15:0];
				idpage_pkg::W_CAP_MSW: word = product[31:16];
				idpage_pkg::W_MULTI: word = {idpage_pkg::V_MULTI_FLAG, cfg.multi};
				idpage_pkg::W_LBA_LSW: word = cfg.total[15:0];
				idpage_pkg::W_LBA_MSW: word = cfg.total[31:16];
				idpage_pkg::W_DMA: begin
					word[2:0] = idpage_pkg::V_DMA_SUPP;
					if (cfg.dma_sel != idpage_pkg::DMA_NONE) begin
						word[cfg.dma_sel + 4'h7] = 1'b1;
					end
				end
				idpage_pkg::W_ADV_PIO: word = idpage_pkg::V_ADV_PIO;
				idpage_pkg::W_DMA_MIN: word = idpage_pkg::V_DMA_NS;
				idpage_pkg::W_DMA_REC: word = idpage_pkg::V_DMA_NS;
				idpage_pkg::W_ERASE: word = cfg.erase_time;
				idpage_pkg::W_APM: word = cfg.apm;
				idpage_pkg::W_SECURITY: word = cfg.sec_status;
				idpage_pkg::W_POWER: word = cfg.pwr_mode;
				default: word = 16'h0000;
			endcase
		end
	end

endmodule : page_word

//--- tb/identify_parameter_page_tb.sv
// Self-checking bench for the identify parameter page generator.
// Assumes the page_sink partner and register access over AXI4-Lite.
`timescale 1ns/1ps
module identify_parameter_page_tb;
	localparam logic [79:0] UID = 80'h4142_4344_4546_4748_494A; // Arbitrary value.
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, ident_start = 1'b0, slow = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rnd = 32'h3388D733, rdata;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, page_valid, page_last, page_ready, busy;
	logic [1:0] bresp, rresp;
	logic [15:0] page_data;
	logic [31:0] rv [11] = '{32'h0010_0100, 32'h20, 32'h0002_0000, 32'h0010_0100, 32'h20,
		32'h0, 32'h0, 32'h0, 32'h2020_2020, 32'h2020_2020, 32'h2020};
	logic [16:0] qp [$];
	logic [33:0] qr [$];
	logic [1:0] qb [$];
	int error_cnt = 0, cmp_count = 0;

	// Free-running 200 MHz clock.
	always #2.5 aclk = ~aclk;

	idpage_top #(.UNIQUE_ID(UID)) uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .ident_start(ident_start), .page_data(page_data),
		.page_valid(page_valid), .page_last(page_last), .page_ready(page_ready), .busy(busy));
	page_sink sink (.aclk(aclk), .aresetn(aresetn), .page_valid(page_valid), .slow(slow),
		.page_ready(page_ready));

	// ****************************************
	// Checking
	// ****************************************
	task automatic print_verdict();
		$display("Comparisons %0d, errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	// Page word compare: busy, last flag and data together.
	task automatic chk_page(input logic [17:0] e, input logic [17:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("Error page expected %h seen %h", e, g);
		end
	endtask : chk_page

	// Write response compare.
	task automatic chk_bresp(input logic [1:0] e, input logic [1:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("Error bresp expected %h seen %h", e, g);
		end
	endtask : chk_bresp

	// Read response and data compare.
	task automatic chk_read(input logic [33:0] e, input logic [33:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("Error read expected %h seen %h", e, g);
		end
	endtask : chk_read

	task automatic guard(inout int n);
		n++;
		if (n > 3000) begin
			error_cnt++;
			$display("Error wait expected done seen timeout");
			print_verdict();
		end
	endtask : guard

	// Each completing handshake is matched against the oldest note of its kind.
	always @(negedge aclk) begin
		if (page_valid && page_ready) begin
			if (qp.size() == 0) chk_page(18'h0, {1'b1, page_last, page_data});
			else chk_page({1'b1, qp.pop_front()}, {busy, page_last, page_data});
		end
		if (bvalid && bready) chk_bresp(qb.pop_front(), bresp);
		if (rvalid && rready) chk_read(qr.pop_front(), {rresp, rdata});
	end

	// Expected page word, worked out from the configuration last written.
	function automatic logic [15:0] ew(input int i);
		logic [31:0] p;
		logic [79:0] s;
		p = rv[3][15:0] * rv[3][31:16] * rv[4][15:0];
		s = {rv[8], rv[9], rv[10][15:0]};
		if (i >= 10 && i <= 14) return s[16 * (14 - i) +: 16];
		if (i >= 15 && i <= 19) return UID[16 * (19 - i) +: 16];
		case (i)
			0: return 16'h044A;
			1: return rv[0][15:0];
			3: return rv[0][31:16];
			6: return rv[1][15:0];
			7, 61: return rv[2][31:16];
			8, 60: return rv[2][15:0];
			20, 21: return 16'h0002;
			22: return 16'h0004;
			47: return 16'h0001;
			49: return 16'h0B00;
			51: return 16'h0200;
			53, 64: return 16'h0003;
			54: return rv[3][15:0];
			55: return rv[3][31:16];
			56: return rv[4][15:0];
			57: return p[15:0];
			58: return p[31:16];
			59: return {8'h01, rv[5][7:0]};
			63: return {5'h0, rv[5][9:8] == 2'h3, rv[5][9:8] == 2'h2, rv[5][9:8] == 2'h1,
				8'h07};
			65, 66: return 16'h0078;
			90: return rv[6][15:0];
			91: return rv[6][31:16];
			128: return rv[7][15:0];
			160: return rv[7][31:16];
			default: return 16'h0000;
		endcase
	endfunction : ew

	// ****************************************
	// Stimulus
	// ****************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = idpage_pkg::RESP_OKAY);
		int n;
		logic ta, tw;
		n = 0;
		ta = 1'b0;
		tw = 1'b0;
		// Let an edge pass so no handshake signal is driven twice in one time step.
		@(posedge aclk);
		qb.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ta && tw)) begin
			@(negedge aclk);
			ta = ta || (awvalid && awready);
			tw = tw || (wvalid && wready);
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			guard(n);
		end
		while (!bvalid) begin
			@(negedge aclk);
			guard(n);
		end
		@(posedge aclk);
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = idpage_pkg::RESP_OKAY);
		int n;
		n = 0;
		// Let an edge pass so rready is never driven twice in one time step.
		@(posedge aclk);
		qr.push_back({r, d});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			guard(n);
		end while (!(arvalid && arready));
		@(posedge aclk);
		arvalid <= 1'b0;
		while (!rvalid) begin
			@(negedge aclk);
			guard(n);
		end
		@(posedge aclk);
		rready <= 1'b0;
	endtask : rd

	task automatic pulse();
		ident_start <= 1'b1;
		@(posedge aclk);
		ident_start <= 1'b0;
	endtask : pulse

	// Main sequence: reset values, refusals, then pages with mid-page reconfiguration.
	initial begin
		int n;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(idpage_pkg::OFF_DEF_GEOM, 32'h0010_0100);
		rd(idpage_pkg::OFF_CTRL, 32'h0);
		rd(8'h40, 32'h0, idpage_pkg::RESP_SLVERR);
		wr(8'h40, rnd, idpage_pkg::RESP_SLVERR);
		// Only byte lane 1 lands: DMA select becomes 1, multiple count stays 0.
		wstrb <= 4'h2;
		wr(idpage_pkg::OFF_MODE, 32'hFFFF_FDFF);
		wstrb <= 4'hF;
		rd(idpage_pkg::OFF_MODE, 32'h0000_0100);
		wr(idpage_pkg::OFF_MODE, 32'h0);
		for (int k = 0; k < 5; k++) begin
			slow <= k[0];
			for (int i = 0; i < 256; i++)
				qp.push_back({i == 255, ew(i)});
			if (k == 2) wr(idpage_pkg::OFF_CTRL, 32'h1);
			else pulse();
			for (int j = 0; j < 11; j++) begin
				rnd = lfsr(rnd);
				rv[j] = (j == 5) ? {22'h0, k[1:0], rnd[7:0]} : rnd;
				wr(8'(4 * j + 4), rv[j]);
			end
			rd(idpage_pkg::OFF_MODE, rv[5]);
			pulse();
			n = 0;
			while (qp.size() != 0) begin
				@(posedge aclk);
				guard(n);
			end
			repeat (4) @(posedge aclk);
			rd(idpage_pkg::OFF_CTRL, 32'h2);
			wr(idpage_pkg::OFF_CTRL, 32'h2);
		end
		rd(idpage_pkg::OFF_CTRL, 32'h0);
		print_verdict();
	end
endmodule : identify_parameter_page_tb

//--- tb/page_sink.sv
// Partner model: the sector transfer engine that drains the page word stream.
// Assumes the stream ports of the page generator and the shared system clock.
`timescale 1ns/1ps
module page_sink (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Stream and pacing
	input wire logic page_valid,
	input wire logic slow,
	output logic page_ready
);
	logic [1:0] ph;
	// sector drain, pauses accepted
	// Ready every cycle, or one cycle in three when slow; device pauses are simply waited out.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ph <= 2'h0;
			page_ready <= 1'b0;
		end else begin
			ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
			page_ready <= !slow || ph == 2'h2;
		end
	end
endmodule : page_sink
